// ### design/sleep_regs.svh
// Constants for the sleep mode and reset controller
`ifndef SLEEP_CTRL_REGS_SVH
`define SLEEP_CTRL_REGS_SVH

// Sleep mode select codes
`define MODE_IDLE          3'h0
`define MODE_NOISE_REDUCE  3'h1
`define MODE_POWER_DOWN    3'h2
`define MODE_POWER_SAVE    3'h3
`define MODE_STANDBY       3'h6
`define MODE_EXT_STANDBY   3'h7

// Clock gate vector bit positions
`define GATE_CPU   0
`define GATE_IO    1
`define GATE_ADC   2
`define GATE_ASY   3
`define GATE_OSC   4
`define GATE_W     5

`define GATES_ALL  5'h1f

// Reset pin minimum low time in ns and derived cycles at 25 MHz
`define RST_MIN_NS      1500
`define CLK_PERIOD_NS   40
`define RST_MIN_CYC     ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W       6

`define PORT_COUNT      4
`define PORT_W          8

`endif

// ### design/sleep_pkg.sv
// Types shared by the sleep mode and reset controller
package sleep_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} power_state_t;
  typedef logic [4:0] gate_vec_t;
  typedef logic [7:0] port_byte_t;
endpackage

// ### design/gate_if.sv
// Interface carrying sleep mode request and clock gate results
`timescale 1ns/1ps
interface gate_if;
  logic [2:0]          mode;
  logic                sleeping;
  sleep_pkg::gate_vec_t gates;
  logic                mode_ok;
  modport ctrl (output mode, output sleeping, input gates, input mode_ok);
  modport dec  (input mode, input sleeping, output gates, output mode_ok);
endinterface

// ### design/gate_decode.sv
// Mode to clock gate decoder
`timescale 1ns/1ps
`include "sleep_regs.svh"
module gate_decode
(
  gate_if.dec g   // Mode and gate vector
);
  import sleep_pkg::*;

  // ****************************************
  // Gate table
  // ****************************************
  function automatic gate_vec_t mode_gates(input logic [2:0] m);
    gate_vec_t v;
    v = '0;
    case (m)
      `MODE_IDLE:         v = `GATES_ALL & ~(5'h1 << `GATE_CPU);
      `MODE_NOISE_REDUCE:
      begin
        v[`GATE_ADC] = 1'b1;
        v[`GATE_ASY] = 1'b1;
        v[`GATE_OSC] = 1'b1;
      end
      `MODE_POWER_DOWN:   v = '0;
      `MODE_POWER_SAVE:   v[`GATE_ASY] = 1'b1;
      `MODE_STANDBY:      v[`GATE_OSC] = 1'b1;
      `MODE_EXT_STANDBY:
      begin
        v[`GATE_OSC] = 1'b1;
        v[`GATE_ASY] = 1'b1;
      end
      default:            v = '0;
    endcase
    return v;
  endfunction

  function automatic logic mode_valid(input logic [2:0] m);
    return (m == `MODE_IDLE) || (m == `MODE_NOISE_REDUCE) || (m == `MODE_POWER_DOWN)
        || (m == `MODE_POWER_SAVE) || (m == `MODE_STANDBY)
        || (m == `MODE_EXT_STANDBY);
  endfunction

  assign g.gates   = g.sleeping ? mode_gates(g.mode) : `GATES_ALL;
  assign g.mode_ok = mode_valid(g.mode);
endmodule

// ### design/sleep_reset_ctrl.sv
// Sleep mode sequencer with external reset filter and port tri-state
`timescale 1ns/1ps
`include "sleep_regs.svh"

module sleep_reset_ctrl
(
  input  wire logic                  clk_i,        // 25 MHz clock
  input  wire logic                  reset_i,      // Async reset, active high
  input  wire logic                  reset_pin_n_i,// External reset pin, active low
  input  wire logic                  sleep_cmd_i,  // Sleep instruction strobe
  input  wire logic                  sleep_en_i,   // Sleep enable level
  input  wire logic [2:0]            mode_i,       // Requested sleep mode
  input  wire logic                  wake_irq_i,   // Wake-up interrupt event
  input  wire logic                  async_irq_i,  // Interrupt from async timer domain
  input  wire sleep_pkg::port_byte_t port_out_i [`PORT_COUNT], // Port output data
  input  wire sleep_pkg::port_byte_t port_dir_i [`PORT_COUNT], // Port direction, 1 drives
  output logic                       cpu_clk_en_o, // CPU clock gate
  output logic                       io_clk_en_o,  // I/O clock gate
  output logic                       adc_clk_en_o, // ADC clock gate
  output logic                       asy_clk_en_o, // Async timer clock gate
  output logic                       osc_en_o,     // Main oscillator enable
  output logic                       sleeping_o,   // Device asleep
  output logic                       sys_reset_o,  // Internal system reset
  output sleep_pkg::port_byte_t      port_o  [`PORT_COUNT], // Port pin output
  output sleep_pkg::port_byte_t      port_oe_o [`PORT_COUNT] // Port pin output enable
);
  import sleep_pkg::*;

  power_state_t          state;
  logic [2:0]            mode;
  logic [`RST_CNT_W-1:0] rst_cnt;
  logic                  pin_reset;
  logic                  any_reset;
  logic                  wake_ok;
  gate_if                g ();

  // ****************************************
  // External reset pin filter
  // ****************************************
  // Counts held-low cycles; a pulse longer than the minimum asserts reset
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rst_cnt <= '0;
    else if (reset_pin_n_i)
      rst_cnt <= '0;
    else if (rst_cnt != `RST_CNT_W'(`RST_MIN_CYC))
      rst_cnt <= rst_cnt + `RST_CNT_W'(1);
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      pin_reset <= 1'b1;
    else
      pin_reset <= (rst_cnt == `RST_CNT_W'(`RST_MIN_CYC)) && !reset_pin_n_i;
  end

  // Async path: reset_i stands for a clockless reset source
  assign any_reset = reset_i | pin_reset;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      sys_reset_o <= 1'b1;
    else
      sys_reset_o <= pin_reset;
  end

  // ****************************************
  // Sleep sequencer
  // ****************************************
  // Any interrupt wakes any mode; the reset pin also ends sleep
  assign wake_ok = wake_irq_i || async_irq_i;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      state <= ST_RUN;
    else if (pin_reset)
      state <= ST_RUN;
    else
    begin
      case (state)
        ST_RUN:
          if (sleep_cmd_i && sleep_en_i && g.mode_ok)
            state <= ST_SLEEP;
        ST_SLEEP:
          if (wake_ok)
            state <= ST_WAKE;
        ST_WAKE:
          state <= ST_RUN;
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // Mode latched at sleep entry so later input changes do not matter
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      mode <= `MODE_IDLE;
    else if (state == ST_RUN && sleep_cmd_i && sleep_en_i)
      mode <= mode_i;
  end

  assign g.mode     = (state == ST_RUN) ? mode_i : mode;
  assign g.sleeping = (state == ST_SLEEP);

  gate_decode u_dec
  (
    .g (g)
  );

  // ****************************************
  // Clock gate outputs
  // ****************************************
  // Only enables are gated; no state is cleared so register contents stay
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cpu_clk_en_o <= 1'b1;
      io_clk_en_o  <= 1'b1;
      adc_clk_en_o <= 1'b1;
      asy_clk_en_o <= 1'b1;
      osc_en_o     <= 1'b1;
      sleeping_o   <= 1'b0;
    end
    else
    begin
      cpu_clk_en_o <= g.gates[`GATE_CPU];
      io_clk_en_o  <= g.gates[`GATE_IO];
      adc_clk_en_o <= g.gates[`GATE_ADC];
      asy_clk_en_o <= g.gates[`GATE_ASY];
      osc_en_o     <= g.gates[`GATE_OSC];
      sleeping_o   <= g.sleeping;
    end
  end

  // ****************************************
  // Port tri-state control
  // ****************************************
  // Async reset clears enables at once, with no clock needed
  genvar p;
  generate
    for (p = 0; p < `PORT_COUNT; p++)
    begin : g_port
      always_ff @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          port_o[p]    <= '0;
          port_oe_o[p] <= '0;
        end
        else if (any_reset)
        begin
          port_o[p]    <= '0;
          port_oe_o[p] <= '0;
        end
        else
        begin
          port_o[p]    <= port_out_i[p];
          port_oe_o[p] <= port_dir_i[p];
        end
      end
    end
  endgenerate
endmodule

// ### tb/sleep_monitor.sv
// Port checker for the sleep and reset controller
`timescale 1ns/1ps
`include "sleep_regs.svh"
module sleep_monitor
(
  input wire logic                  clk_i,         // Clock
  input wire logic                  reset_i,       // Reset
  input wire logic                  reset_pin_n_i, // Pin
  input wire logic                  sleep_cmd_i,   // Strobe
  input wire logic                  sleep_en_i,    // Enable
  input wire logic [2:0]            mode_i,        // Mode
  input wire logic                  wake_irq_i,    // Wake
  input wire logic                  async_irq_i,   // Wake
  input wire logic                  cpu_clk_en_o,  // Gate
  input wire logic                  io_clk_en_o,   // Gate
  input wire logic                  adc_clk_en_o,  // Gate
  input wire logic                  asy_clk_en_o,  // Gate
  input wire logic                  osc_en_o,      // Gate
  input wire logic                  sleeping_o,    // Asleep
  input wire logic                  sys_reset_o,   // Reset out
  input wire sleep_pkg::port_byte_t port_oe_o [`PORT_COUNT] // Enables
);
  import sleep_pkg::*;
  logic [4:0] g;
  logic [5:0] low_cnt;
  assign g = {osc_en_o, asy_clk_en_o, adc_clk_en_o, io_clk_en_o, cpu_clk_en_o};
  function automatic logic [4:0] exp_g(input logic [2:0] m);
    case (m)
      `MODE_IDLE:         return 5'h1e;
      `MODE_NOISE_REDUCE: return 5'h1c;
      `MODE_POWER_DOWN:   return 5'h00;
      `MODE_POWER_SAVE:   return 5'h08;
      `MODE_STANDBY:      return 5'h10;
      default:            return 5'h18;
    endcase
  endfunction
  // Counts cycles with the pin held low
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      low_cnt <= 6'h00;
    else if (reset_pin_n_i)
      low_cnt <= 6'h00;
    else if (low_cnt != 6'h3f)
      low_cnt <= low_cnt + 6'h01;
  end
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_mode_gates: assert property ($rose(sleeping_o) |-> g == exp_g($past(mode_i, 2)))
    else $error("gates wrong");
  chk_run_gates: assert property (!sleeping_o && !sys_reset_o |-> g == 5'h1f)
    else $error("run gates off");
  chk_wake_restore: assert property (sleeping_o && (wake_irq_i || async_irq_i) |->
    ##[1:2] (!sleeping_o && g == 5'h1f)) else $error("no wake");
  chk_cmd_only: assert property ($rose(sleeping_o) |-> $past(sleep_cmd_i && sleep_en_i, 2))
    else $error("sleep without command");
  chk_sleep_disabled: assert property (sleep_cmd_i && !sleep_en_i && !sleeping_o |->
    ##2 !sleeping_o) else $error("disabled sleep");
  chk_bad_mode: assert property (sleep_cmd_i && mode_i inside {3'h4, 3'h5} && !sleeping_o
    |-> ##2 !sleeping_o) else $error("bad mode slept");
  chk_pin_reset: assert property (low_cnt >= 6'h29 |-> sys_reset_o)
    else $error("pin reset missed");
  chk_port_tristate: assert property (sys_reset_o |->
    (port_oe_o[0] | port_oe_o[1] | port_oe_o[2] | port_oe_o[3]) == 8'h00) else $error("ports on");
  cover property ($rose(sleeping_o));
  cover property ($fell(sleeping_o));
  cover property (low_cnt == 6'h29);
endmodule

bind sleep_reset_ctrl sleep_monitor i_mon (.clk_i, .reset_i, .reset_pin_n_i, .sleep_cmd_i,
  .sleep_en_i, .mode_i, .wake_irq_i, .async_irq_i, .cpu_clk_en_o, .io_clk_en_o, .adc_clk_en_o,
  .asy_clk_en_o, .osc_en_o, .sleeping_o, .sys_reset_o, .port_oe_o);

// ### tb/testbench.sv
// Self-checking bench for the sleep and reset controller
`timescale 1ns/1ps
`include "sleep_regs.svh"
module testbench;
  import sleep_pkg::*;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       reset_pin_n_i = 1'b1;
  logic       sleep_cmd_i = 1'b0;
  logic       sleep_en_i = 1'b1;
  logic [2:0] mode_i = 3'h0;
  logic       wake_irq_i = 1'b0;
  logic       async_irq_i = 1'b0;
  logic       cpu_clk_en_o, io_clk_en_o, adc_clk_en_o, asy_clk_en_o, osc_en_o;
  logic       sleeping_o, sys_reset_o;
  logic [4:0] g;
  port_byte_t port_out_i [`PORT_COUNT] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
  port_byte_t port_dir_i [`PORT_COUNT] = '{default: 8'hff};
  port_byte_t port_o [`PORT_COUNT];
  port_byte_t port_oe_o [`PORT_COUNT];
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [4:0] gates [6] = '{5'h1e, 5'h1c, 5'h00, 5'h08, 5'h10, 5'h18};
  int         errors = 0;
  int         checks_done = 0;
  assign g = {osc_en_o, asy_clk_en_o, adc_clk_en_o, io_clk_en_o, cpu_clk_en_o};
  always #20 clk_i = ~clk_i;
  sleep_reset_ctrl i_dut (.clk_i, .reset_i, .reset_pin_n_i, .sleep_cmd_i, .sleep_en_i, .mode_i,
    .wake_irq_i, .async_irq_i, .port_out_i, .port_dir_i, .cpu_clk_en_o, .io_clk_en_o,
    .adc_clk_en_o, .asy_clk_en_o, .osc_en_o, .sleeping_o, .sys_reset_o, .port_o, .port_oe_o);
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic sleep_wake(input logic [2:0] m, input logic [4:0] exp, input logic use_async);
    @(posedge clk_i);
    sleep_cmd_i <= 1'b1;
    mode_i <= m;
    @(posedge clk_i);
    sleep_cmd_i <= 1'b0;
    #1;
    check(sleeping_o, 1'b0);
    tick(7);
    check(g, exp);
    check(sleeping_o, 1'b1);
    @(posedge clk_i);
    if (use_async)
      async_irq_i <= 1'b1;
    else
      wake_irq_i <= 1'b1;
    @(posedge clk_i);
    async_irq_i <= 1'b0;
    wake_irq_i <= 1'b0;
    tick(2);
    check(g, 5'h1f);
    check(sleeping_o, 1'b0);
    tick(1);
  endtask
  task automatic refused(input logic en, input logic [2:0] m);
    @(posedge clk_i);
    sleep_cmd_i <= 1'b1;
    sleep_en_i <= en;
    mode_i <= m;
    @(posedge clk_i);
    sleep_cmd_i <= 1'b0;
    sleep_en_i <= 1'b1;
    tick(4);
    check(g, 5'h1f);
  endtask
  task automatic pin_reset;
    check(port_oe_o[3], 8'hff);
    @(posedge clk_i);
    reset_pin_n_i <= 1'b0;
    tick(30);
    check(sys_reset_o, 1'b0);
    tick(14);
    check(sys_reset_o, 1'b1);
    for (int i = 0; i < 4; i++) check(port_oe_o[i], 8'h00);
    @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    tick(6);
    check(sys_reset_o, 1'b0);
    check(port_o[0], 8'h5a);
  endtask
  task automatic async_reset;
    @(posedge clk_i);
    reset_i <= 1'b1;
    #1;
    check(port_oe_o[1], 8'h00);
    tick(3);
    @(posedge clk_i);
    reset_i <= 1'b0;
    tick(3);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    tick(3);
    for (int i = 0; i < 6; i++) sleep_wake(modes[i], gates[i], i[0]);
    refused(1'b0, 3'h0);
    refused(1'b1, 3'h4);
    refused(1'b1, 3'h5);
    pin_reset;
    async_reset;
    sleep_wake(3'h7, 5'h18, 1'b1);
    tally_and_finish;
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    errors++;
    tally_and_finish;
  end
endmodule
